// >>> dv/pcc_checker_tb.sv
/*
  self-checking bench for the packet channel state checker.
  assumes the terminal model drives packets; the bench drives the rest.
*/
`timescale 1ns/1ps
module pcc_checker_tb;
  import pcc_pkg::*;
  // ==========================================================
  // sizes; time-out shortened so forced completion shows quickly
  localparam int CHANNELS = 16;
  localparam int CW = 4;
  localparam logic [AGE_W-1:0] TO_TICKS = 8'h02;
  localparam int LIMIT = 6000; // cycles; the run needs about 450
  // ==========================================================
  // signals
  logic core_clk;
  logic reset;
  logic [CHANNELS-1:0] chan_pvc; // permanent circuit map
  logic pkt_valid;
  pcc_pkt_t pkt_kind;
  logic [CW-1:0] pkt_chan;
  logic net_valid;
  pcc_net_t net_kind;
  logic [CW-1:0] net_chan;
  logic net_ready;
  logic verdict_valid;
  logic verdict_error;
  logic ind_valid;
  pcc_ind_t ind_kind;
  logic [CW-1:0] ind_chan;
  pcc_cause_t ind_cause;
  logic rem_valid;
  pcc_ind_t rem_kind;
  logic [CW-1:0] rem_chan;
  pcc_cause_t rem_cause;
  logic timeout_fire;
  logic restart_busy;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int slow = 0; // idle cycles the terminal waits before each packet

  pcc_checker #(.CHANNELS(CHANNELS), .CW(CW), .TIMEOUT_TICKS(TO_TICKS)) pcc_checker_inst (
    .core_clk(core_clk), .reset(reset), .chan_pvc(chan_pvc), .pkt_valid(pkt_valid),
    .pkt_kind(pkt_kind), .pkt_chan(pkt_chan), .net_valid(net_valid), .net_kind(net_kind),
    .net_chan(net_chan), .net_ready(net_ready), .verdict_valid(verdict_valid),
    .verdict_error(verdict_error), .ind_valid(ind_valid), .ind_kind(ind_kind), .ind_chan(ind_chan),
    .ind_cause(ind_cause), .rem_valid(rem_valid), .rem_kind(rem_kind), .rem_chan(rem_chan),
    .rem_cause(rem_cause), .timeout_fire(timeout_fire), .restart_busy(restart_busy));
  pcc_dte_model #(.CW(CW)) pcc_dte_model_inst (
    .core_clk(core_clk), .pkt_valid(pkt_valid), .pkt_kind(pkt_kind), .pkt_chan(pkt_chan),
    .ind_valid(ind_valid));

  // ==========================================================
  // clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // a stuck handshake ends the run as a failure
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      test_done;
    end
  end

  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // send one packet, then judge the verdict and indications one cycle on
  task automatic pk(input pcc_pkt_t k, input int c, input logic err, input pcc_ind_t ik, input logic rem);
    pcc_dte_model_inst.send(k, CW'(c), slow);
    #1;
    chk("verdict_valid", 1'b1, verdict_valid);
    chk("verdict_error", err, verdict_error);
    chk("ind_valid", err, ind_valid);
    chk("rem_valid", rem, rem_valid);
    if (err) begin
      chk("ind_kind", ik, ind_kind);
      chk("ind_chan", 8'(c), ind_chan);
      chk("ind_cause", CAUSE_LOCAL_PROC, ind_cause);
    end
    if (rem) begin
      chk("rem_chan", 8'(c), rem_chan);
      chk("rem_kind", ik, rem_kind);
      chk("rem_cause", CAUSE_REMOTE_PROC, rem_cause);
    end
  endtask
  // one network event; only taken while no packet is offered
  task automatic net(input pcc_net_t k, input int c);
    @(posedge core_clk);
    net_valid <= 1'b1;
    net_kind <= k;
    net_chan <= CW'(c);
    @(posedge core_clk);
    net_valid <= 1'b0;
    net_chan <= ~net_chan;
  endtask
  task automatic test_done;
    if (err_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    chk("verdict_valid", 1'b0, verdict_valid);
    chk("ind_valid", 1'b0, ind_valid);
    chk("rem_valid", 1'b0, rem_valid);
    chk("ind_cause", CAUSE_NONE, ind_cause);
    chk("restart_busy", 1'b0, restart_busy);
    chk("net_ready", 1'b1, net_ready);
  endtask
  // call set-up and clearing on channels 3 and 5, collisions on channel 4
  task automatic t_call;
    pk(PK_DATA, 3, 1, IND_CLEAR, 0);
    pk(PK_INTR, 3, 0, IND_CLEAR, 0);
    pk(PK_CALL_ACC, 3, 0, IND_CLEAR, 0);
    pk(PK_CLR_CONF, 3, 0, IND_CLEAR, 0);
    pk(PK_CLR_CONF, 3, 1, IND_CLEAR, 0);
    pk(PK_CLR_REQ, 3, 0, IND_CLEAR, 0);
    pk(PK_CALL_REQ, 3, 0, IND_CLEAR, 0);
    pk(PK_CALL_ACC, 3, 1, IND_CLEAR, 0);
    pk(PK_CLR_CONF, 3, 0, IND_CLEAR, 0);
    net(NE_INCOMING_CALL, 4);
    pk(PK_CALL_REQ, 4, 0, IND_CLEAR, 0);
    pk(PK_RST_REQ, 4, 1, IND_CLEAR, 0);
    pk(PK_CLR_CONF, 4, 0, IND_CLEAR, 0);
    pk(PK_CLR_REQ, 4, 0, IND_CLEAR, 0);
    pk(PK_FLOW, 4, 1, IND_CLEAR, 0);
    pk(PK_CLR_CONF, 4, 0, IND_CLEAR, 0);
    pk(PK_CALL_REQ, 5, 0, IND_CLEAR, 0);
    net(NE_CALL_CONNECTED, 5);
    net(NE_RST_IND, 5);
    pk(PK_RST_CONF, 5, 0, IND_CLEAR, 0);
    net(NE_CLR_IND, 5);
    pk(PK_CLR_CONF, 5, 0, IND_CLEAR, 0);
  endtask
  // reset substates of a connected call, with a slow terminal
  task automatic t_flow;
    net(NE_INCOMING_CALL, 1);
    pk(PK_CALL_ACC, 1, 0, IND_CLEAR, 0);
    slow = 2;
    pk(PK_DATA, 1, 0, IND_CLEAR, 0);
    pk(PK_RST_CONF, 1, 1, IND_RESET, 1);
    pk(PK_INTR, 1, 0, IND_CLEAR, 0);
    pk(PK_RST_CONF, 1, 0, IND_CLEAR, 0);
    pk(PK_RST_REQ, 1, 0, IND_CLEAR, 0);
    pk(PK_RST_REQ, 1, 0, IND_CLEAR, 0);
    pk(PK_FLOW, 1, 1, IND_RESET, 1);
    pk(PK_RST_REQ, 1, 0, IND_CLEAR, 0);
    slow = 0;
    pk(PK_CALL_REQ, 1, 1, IND_CLEAR, 1);
  endtask
  // unconfirmed clear indication completes by network time-out
  task automatic t_timeout;
    int n = 0;
    while (timeout_fire !== 1'b1 && n < 2000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("timeout_fire", 1'b1, timeout_fire);
    chk("timeout_window", 1'b1, n >= TICK_CYC * (int'(TO_TICKS) - 1) && n <= TICK_CYC * (int'(TO_TICKS) + 3));
    pk(PK_CLR_CONF, 1, 1, IND_CLEAR, 0);
    pk(PK_CLR_CONF, 1, 0, IND_CLEAR, 0);
  endtask
  // restart error, restart indication state and completion
  task automatic t_restart;
    @(posedge core_clk);
    chan_pvc <= 16'h0004;
    pk(PK_DATA, 1, 1, IND_CLEAR, 0);
    pk(PK_RSTART_CONF, 0, 1, IND_RESTART, 0);
    chk("restart_busy", 1'b1, restart_busy);
    pk(PK_DATA, 5, 0, IND_CLEAR, 0);
    pk(PK_CALL_ACC, 5, 0, IND_CLEAR, 0);
    pk(PK_RSTART_CONF, 0, 0, IND_CLEAR, 0);
    chk("restart_busy", 1'b0, restart_busy);
    pk(PK_CALL_REQ, 1, 0, IND_CLEAR, 0);
    pk(PK_DATA, 2, 0, IND_CLEAR, 0);
    pk(PK_DATA, 3, 1, IND_CLEAR, 0);
  endtask
  // terminal-initiated restart and errors while it is pending
  task automatic t_dte_restart;
    pk(PK_RSTART_REQ, 0, 0, IND_CLEAR, 0);
    chk("restart_busy", 1'b1, restart_busy);
    pk(PK_RSTART_REQ, 7, 0, IND_CLEAR, 0);
    net(NE_RSTART_CONF, 0);
    #1;
    chk("restart_busy", 1'b0, restart_busy);
    pk(PK_RSTART_REQ, 0, 0, IND_CLEAR, 0);
    pk(PK_CLR_REQ, 0, 1, IND_RESTART, 0);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    reset = 1'b1;
    chan_pvc = '0;
    net_valid = 1'b0;
    net_kind = NE_CLR_CONF;
    net_chan = '0;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    #1;
    t_reset;
    t_call;
    t_flow;
    t_timeout;
    t_restart;
    t_dte_restart;
    test_done;
  end
endmodule

bind pcc_checker pcc_prop_checker #(.CW(CW)) pcc_prop_checker_inst (
  .core_clk(core_clk), .reset(reset), .pkt_valid(pkt_valid), .pkt_kind(pkt_kind),
  .verdict_valid(verdict_valid), .verdict_error(verdict_error), .ind_valid(ind_valid),
  .ind_kind(ind_kind), .ind_chan(ind_chan), .ind_cause(ind_cause), .rem_valid(rem_valid),
  .rem_kind(rem_kind), .rem_chan(rem_chan), .rem_cause(rem_cause), .timeout_fire(timeout_fire),
  .restart_busy(restart_busy));

// >>> dv/pcc_dte_model.sv
/*
  behavioural packet-mode terminal facing the checker.
  assumes the bench calls send and that core_clk runs free.
*/
`timescale 1ns/1ps
module pcc_dte_model
  import pcc_pkg::*;
#(
  parameter int CW = 4
)(
  input wire logic core_clk,
  output logic pkt_valid,
  output pcc_pkt_t pkt_kind,
  output logic [CW-1:0] pkt_chan,
  input wire logic ind_valid
);
  // ==========================================================
  // state
  int ind_seen; // indications taken from the network side
  // idle at time zero, nothing offered
  initial begin
    pkt_valid = 1'b0;
    pkt_kind = PK_FLOW;
    pkt_chan = '0;
    ind_seen = 0;
  end
  // a terminal consumes every indication, it cannot push back
  always @(posedge core_clk) begin
    if (ind_valid === 1'b1) begin
      ind_seen <= ind_seen + 1;
    end
  end
  // ==========================================================
  // one packet after gap idle cycles; the pulse lasts one cycle
  task automatic send(input pcc_pkt_t k, input logic [CW-1:0] c, input int gap);
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    pkt_valid <= 1'b1;
    pkt_kind <= k;
    pkt_chan <= c;
    @(posedge core_clk);
    pkt_valid <= 1'b0;
    // stale fields scrambled so nothing leans on them after the pulse
    pkt_kind <= pcc_pkt_t'(~k);
    pkt_chan <= ~c;
  endtask
endmodule

// >>> dv/pcc_prop_checker.sv
/*
  concurrent properties on the ports of the packet channel state checker.
  assumes it is bound onto pcc_checker and that all ports sit on core_clk.
*/
`timescale 1ns/1ps
module pcc_prop_checker
  import pcc_pkg::*;
#(
  parameter int CW = 4
)(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic pkt_valid,
  input wire pcc_pkt_t pkt_kind,
  input wire logic verdict_valid,
  input wire logic verdict_error,
  input wire logic ind_valid,
  input wire pcc_ind_t ind_kind,
  input wire logic [CW-1:0] ind_chan,
  input wire pcc_cause_t ind_cause,
  input wire logic rem_valid,
  input wire pcc_ind_t rem_kind,
  input wire logic [CW-1:0] rem_chan,
  input wire pcc_cause_t rem_cause,
  input wire logic timeout_fire,
  input wire logic restart_busy
);
  // ==========================================================
  // one domain, so clock and reset are given once
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // ==========================================================
  // verdict timing: exactly one verdict a cycle after each packet
  AST_VERDICT_FOLLOWS: assert property (pkt_valid |=> verdict_valid)
    else $error("no verdict after a packet");
  AST_NO_STRAY_VERDICT: assert property (!pkt_valid |=> !verdict_valid)
    else $error("verdict without a packet");

  // ==========================================================
  // error handling: every error answers the terminal with a local cause
  AST_ERR_LOCAL_IND: assert property (verdict_valid && verdict_error |->
    ind_valid && ind_cause == CAUSE_LOCAL_PROC)
    else $error("error without local indication");
  AST_IND_ON_ERR_ONLY: assert property (ind_valid == (verdict_valid && verdict_error))
    else $error("indication not tied to an error verdict");
  // the distant end hears the same event on the same channel
  AST_REM_MIRRORS: assert property (rem_valid |-> ind_valid && rem_kind == ind_kind
    && rem_chan == ind_chan && rem_cause == CAUSE_REMOTE_PROC)
    else $error("distant indication does not mirror local one");
  AST_FLOW_ERR_REMOTE: assert property (ind_valid && ind_kind == IND_RESET |-> rem_valid)
    else $error("flow error not sent to distant end");
  // restart errors stay local and leave the interface restarting
  AST_RESTART_LOCAL: assert property (ind_valid && ind_kind == IND_RESTART |->
    !rem_valid && restart_busy)
    else $error("restart error handled wrongly");

  // ==========================================================
  // packets with a fixed verdict; a restart confirmation outside restart is an error
  AST_CLR_REQ_NORMAL: assert property (pkt_valid && pkt_kind == PK_CLR_REQ && !restart_busy
    |=> !verdict_error)
    else $error("clear request flagged as error");
  AST_RSTART_REQ_NORMAL: assert property (pkt_valid && pkt_kind == PK_RSTART_REQ
    |=> verdict_valid && !verdict_error && !ind_valid)
    else $error("restart request flagged as error");
  AST_RSTART_CONF_IDLE: assert property (pkt_valid && pkt_kind == PK_RSTART_CONF && !restart_busy
    |=> verdict_error && ind_kind == IND_RESTART)
    else $error("stray restart confirmation accepted");

  // ==========================================================
  // main scenarios reached
  COV_FLOW_ERR: cover property (ind_valid && ind_kind == IND_RESET);
  COV_REM_CLEAR: cover property (rem_valid && rem_kind == IND_CLEAR);
  COV_TIMEOUT: cover property (timeout_fire);
  COV_RESTART: cover property ($rose(restart_busy));
endmodule

// >>> src/pcc_checker.sv
/*
  per-channel packet level state checker on the network side.
  judges each terminal packet, tracks call, reset and restart states,
  and raises local indications on procedure errors, distant ones only on flow errors and on data transfer clears of non-permanent channels.
  assumes inputs synchronous to core_clk and a terminal that issues at most
  one packet per cycle; network events yield to terminal packets.
*/
`timescale 1ns/1ps
module pcc_checker
  import pcc_pkg::*;
#(
  parameter int CHANNELS = 16,
  parameter int CW = 4,
  parameter logic [AGE_W-1:0] TIMEOUT_TICKS = AGE_W'(TIMEOUT_TICKS_DEF)
)(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [CHANNELS-1:0] chan_pvc,
  input wire logic pkt_valid,
  input wire pcc_pkt_t pkt_kind,
  input wire logic [CW-1:0] pkt_chan,
  input wire logic net_valid,
  input wire pcc_net_t net_kind,
  input wire logic [CW-1:0] net_chan,
  output logic net_ready,
  output logic verdict_valid,
  output logic verdict_error,
  output logic ind_valid,
  output pcc_ind_t ind_kind,
  output logic [CW-1:0] ind_chan,
  output pcc_cause_t ind_cause,
  output logic rem_valid,
  output pcc_ind_t rem_kind,
  output logic [CW-1:0] rem_chan,
  output pcc_cause_t rem_cause,
  output logic timeout_fire,
  output logic restart_busy
);

  // =====================================================
  // tick source
  pcc_tick_if tk ();
  pcc_tick_gen pcc_tick_gen_inst (
    .core_clk(core_clk),
    .reset(reset),
    .t(tk.src)
  );

  // =====================================================
  // state
  pcc_call_t cs_r [CHANNELS]; // call state per channel
  pcc_call_t cs_nxt [CHANNELS];
  pcc_sub_t sub_r [CHANNELS]; // data transfer substate per channel
  pcc_sub_t sub_nxt [CHANNELS];
  logic [AGE_W-1:0] age_r [CHANNELS]; // ticks spent awaiting confirmation
  logic [AGE_W-1:0] age_nxt [CHANNELS];
  pcc_rs_t rs_r; // restart state, shared by all channels
  pcc_rs_t rs_nxt;
  logic [AGE_W-1:0] rage_r; // restart time-out age
  logic [AGE_W-1:0] rage_nxt;
  logic vv_r, vv_nxt, ve_r, ve_nxt; // verdict pulse and error flag
  logic iv_r, iv_nxt; // local indication pulse
  pcc_ind_t ik_r, ik_nxt;
  logic [CW-1:0] ic_r, ic_nxt;
  pcc_cause_t ica_r, ica_nxt;
  logic rv_r, rv_nxt; // distant indication pulse
  pcc_ind_t rk_r, rk_nxt;
  logic [CW-1:0] rc_r, rc_nxt;
  pcc_cause_t rca_r, rca_nxt;
  logic to_r, to_nxt; // time-out fired pulse

  // a channel is awaiting a terminal confirmation of our indication
  function automatic logic timed(input pcc_call_t c, input pcc_sub_t s);
    timed = (c == dce_clear_indication_state) ||
            (c == data_transfer_state && s == dce_reset_indication_substate);
  endfunction

  // =====================================================
  // next-state logic
  always_comb begin
    pcc_call_t st;
    pcc_sub_t sb;
    logic pvc, clr_err, flow_err, rs_err, rs_done;
    st = ready_state;
    sb = flow_ready_substate;
    pvc = 1'b0;
    clr_err = 1'b0;
    flow_err = 1'b0;
    rs_err = 1'b0;
    rs_done = 1'b0;
    rs_nxt = rs_r;
    rage_nxt = rage_r;
    vv_nxt = 1'b0;
    ve_nxt = 1'b0;
    iv_nxt = 1'b0;
    ik_nxt = ik_r;
    ic_nxt = ic_r;
    ica_nxt = CAUSE_NONE;
    rv_nxt = 1'b0;
    rk_nxt = rk_r;
    rc_nxt = rc_r;
    rca_nxt = CAUSE_NONE;
    to_nxt = 1'b0;
    // time-outs first, so a packet is judged against the forced state
    for (int i = 0; i < CHANNELS; i++) begin
      cs_nxt[i] = cs_r[i];
      sub_nxt[i] = sub_r[i];
      age_nxt[i] = AGE_RESET;
      if (rs_r == RS_IDLE && timed(cs_r[i], sub_r[i])) begin
        age_nxt[i] = age_r[i];
        if (age_r[i] >= TIMEOUT_TICKS) begin
          // no confirmation came: complete as if confirmed
          to_nxt = 1'b1;
          age_nxt[i] = AGE_RESET;
          if (cs_r[i] == dce_clear_indication_state) begin
            cs_nxt[i] = chan_pvc[i] ? data_transfer_state : ready_state;
          end else begin
            sub_nxt[i] = flow_ready_substate;
          end
        end else if (tk.tick) begin
          age_nxt[i] = age_r[i] + AGE_W'(1);
        end
      end
    end
    // restart indication time-out
    if (rs_r == RS_DCE_IND) begin
      if (rage_r >= TIMEOUT_TICKS) begin
        rs_done = 1'b1;
        to_nxt = 1'b1;
      end else if (tk.tick) begin
        rage_nxt = rage_r + AGE_W'(1);
      end
    end else begin
      rage_nxt = AGE_RESET;
    end
    if (pkt_valid) begin
      vv_nxt = 1'b1;
      st = cs_nxt[pkt_chan];
      sb = sub_nxt[pkt_chan];
      pvc = chan_pvc[pkt_chan];
      if (pkt_kind == PK_RSTART_REQ) begin
        // always normal; collides into completion when we were indicating
        if (rs_r == RS_DCE_IND) begin
          rs_done = 1'b1;
        end else begin
          rs_nxt = RS_DTE_REQ;
        end
      end else if (pkt_kind == PK_RSTART_CONF) begin
        if (rs_r == RS_DCE_IND) begin
          rs_done = 1'b1;
        end else begin
          rs_err = 1'b1;
        end
      end else if (rs_r == RS_DTE_REQ) begin
        rs_err = 1'b1;
      end else if (rs_r == RS_DCE_IND) begin
        // handled normally: no channel effect while our restart indication is pending
        rs_err = 1'b0;
      end else begin
        case (pkt_kind)
          PK_CALL_REQ: begin
            if (st == ready_state) begin
              cs_nxt[pkt_chan] = dte_waiting_state;
            end else if (st == dce_waiting_state) begin
              cs_nxt[pkt_chan] = call_collision_state;
            end else begin
              clr_err = 1'b1;
            end
          end
          PK_CALL_ACC: begin
            if (st == dce_waiting_state) begin
              cs_nxt[pkt_chan] = data_transfer_state;
              sub_nxt[pkt_chan] = flow_ready_substate;
            end else if (st != dce_clear_indication_state) begin
              clr_err = 1'b1;
            end
          end
          PK_CLR_REQ: begin
            // always accepted; against our own clear it completes the clearing
            cs_nxt[pkt_chan] = (st == dce_clear_indication_state) ? ready_state
                                                                  : dte_clear_request_state;
          end
          PK_CLR_CONF: begin
            if (st == dce_clear_indication_state) begin
              cs_nxt[pkt_chan] = pvc ? data_transfer_state : ready_state;
            end else begin
              clr_err = 1'b1;
            end
          end
          PK_DATA, PK_INTR, PK_FLOW: begin
            if (st == data_transfer_state) begin
              flow_err = (sb == dte_reset_request_substate);
            end else if (st != dce_clear_indication_state) begin
              clr_err = 1'b1;
            end
          end
          PK_RST_REQ: begin
            if (st == data_transfer_state) begin
              // reset collision against our indication completes the reset
              sub_nxt[pkt_chan] = (sb == dce_reset_indication_substate) ? flow_ready_substate
                                                                        : dte_reset_request_substate;
            end else if (st != dce_clear_indication_state) begin
              clr_err = 1'b1;
            end
          end
          PK_RST_CONF: begin
            if (st == data_transfer_state) begin
              if (sb == dce_reset_indication_substate) begin
                sub_nxt[pkt_chan] = flow_ready_substate;
              end else begin
                flow_err = 1'b1;
              end
            end else if (st != dce_clear_indication_state) begin
              clr_err = 1'b1;
            end
          end
          default: begin
            clr_err = 1'b0;
          end
        endcase
      end
    end else if (net_valid) begin
      // network progress events; ones that do not fit the state are dropped
      st = cs_nxt[net_chan];
      sb = sub_nxt[net_chan];
      case (net_kind)
        NE_RSTART_CONF: rs_done = (rs_r == RS_DTE_REQ);
        NE_RSTART_IND: begin
          if (rs_r == RS_DTE_REQ) begin
            rs_done = 1'b1;
          end else if (rs_r == RS_IDLE) begin
            rs_nxt = RS_DCE_IND;
          end
        end
        default: begin
          if (rs_r == RS_IDLE) begin
            case (net_kind)
              NE_INCOMING_CALL: if (st == ready_state) cs_nxt[net_chan] = dce_waiting_state;
              NE_CALL_CONNECTED: begin
                if (st == dte_waiting_state || st == call_collision_state) begin
                  cs_nxt[net_chan] = data_transfer_state;
                  sub_nxt[net_chan] = flow_ready_substate;
                end
              end
              NE_CLR_CONF: if (st == dte_clear_request_state) cs_nxt[net_chan] = ready_state;
              NE_CLR_IND: begin
                cs_nxt[net_chan] = (st == dte_clear_request_state) ? ready_state
                                                                   : dce_clear_indication_state;
              end
              NE_RST_CONF: begin
                if (st == data_transfer_state && sb == dte_reset_request_substate) begin
                  sub_nxt[net_chan] = flow_ready_substate;
                end
              end
              NE_RST_IND: begin
                if (st == data_transfer_state) begin
                  sub_nxt[net_chan] = (sb == dte_reset_request_substate) ? flow_ready_substate
                                                                         : dce_reset_indication_substate;
                end
              end
              default: begin
                rs_nxt = rs_r;
              end
            endcase
          end
        end
      endcase
    end
    // error actions
    if (clr_err) begin
      ve_nxt = 1'b1;
      iv_nxt = 1'b1;
      ik_nxt = IND_CLEAR;
      ic_nxt = pkt_chan;
      ica_nxt = CAUSE_LOCAL_PROC;
      cs_nxt[pkt_chan] = dce_clear_indication_state;
      sub_nxt[pkt_chan] = flow_ready_substate;
      if (!pvc && st == data_transfer_state) begin
        rv_nxt = 1'b1;
        rk_nxt = IND_CLEAR;
        rc_nxt = pkt_chan;
        rca_nxt = CAUSE_REMOTE_PROC;
      end
    end
    if (flow_err) begin
      ve_nxt = 1'b1;
      iv_nxt = 1'b1;
      ik_nxt = IND_RESET;
      ic_nxt = pkt_chan;
      ica_nxt = CAUSE_LOCAL_PROC;
      sub_nxt[pkt_chan] = dce_reset_indication_substate;
      rv_nxt = 1'b1;
      rk_nxt = IND_RESET;
      rc_nxt = pkt_chan;
      rca_nxt = CAUSE_REMOTE_PROC;
    end
    if (rs_err) begin
      ve_nxt = 1'b1;
      iv_nxt = 1'b1;
      ik_nxt = IND_RESTART;
      ic_nxt = pkt_chan;
      ica_nxt = CAUSE_LOCAL_PROC;
      rs_nxt = RS_DCE_IND;
    end
    // restart completion acts on every channel together
    if (rs_done) begin
      rs_nxt = RS_IDLE;
      for (int i = 0; i < CHANNELS; i++) begin
        cs_nxt[i] = chan_pvc[i] ? data_transfer_state : ready_state;
        sub_nxt[i] = flow_ready_substate;
        age_nxt[i] = AGE_RESET;
      end
    end
  end

  // =====================================================
  // registers only
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < CHANNELS; i++) begin
        cs_r[i] <= ready_state;
        sub_r[i] <= flow_ready_substate;
        age_r[i] <= AGE_RESET;
      end
      rs_r <= RS_IDLE;
      rage_r <= AGE_RESET;
      vv_r <= 1'b0;
      ve_r <= 1'b0;
      iv_r <= 1'b0;
      ik_r <= IND_CLEAR;
      ic_r <= '0;
      ica_r <= CAUSE_NONE;
      rv_r <= 1'b0;
      rk_r <= IND_CLEAR;
      rc_r <= '0;
      rca_r <= CAUSE_NONE;
      to_r <= 1'b0;
    end else begin
      cs_r <= cs_nxt;
      sub_r <= sub_nxt;
      age_r <= age_nxt;
      rs_r <= rs_nxt;
      rage_r <= rage_nxt;
      vv_r <= vv_nxt;
      ve_r <= ve_nxt;
      iv_r <= iv_nxt;
      ik_r <= ik_nxt;
      ic_r <= ic_nxt;
      ica_r <= ica_nxt;
      rv_r <= rv_nxt;
      rk_r <= rk_nxt;
      rc_r <= rc_nxt;
      rca_r <= rca_nxt;
      to_r <= to_nxt;
    end
  end

  // =====================================================
  // outputs
  assign net_ready = !pkt_valid; // terminal packets take priority
  assign verdict_valid = vv_r;
  assign verdict_error = ve_r;
  assign ind_valid = iv_r;
  assign ind_kind = ik_r;
  assign ind_chan = ic_r;
  assign ind_cause = ica_r;
  assign rem_valid = rv_r;
  assign rem_kind = rk_r;
  assign rem_chan = rc_r;
  assign rem_cause = rca_r;
  assign timeout_fire = to_r;
  assign restart_busy = (rs_r != RS_IDLE);

endmodule

// >>> src/pcc_pkg.sv
/*
  shared constants and types of the packet channel state checker.
  assumes a single 200 MHz core clock and synchronous active-high reset.
*/
package pcc_pkg;

  // =====================================================
  // timing
  localparam int CLK_PERIOD_NS = 5;         // 200 MHz core clock
  localparam int TICK_NS = 1000;            // time-out tick period
  localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = 8;                // width of the tick prescaler
  localparam int AGE_W = 8;                 // width of a time-out age counter
  localparam int TIMEOUT_TICKS_DEF = 200;   // default network time-out in ticks
  localparam logic [AGE_W-1:0] AGE_RESET = 8'h00;

  // =====================================================
  // call states of one logical channel
  typedef enum logic [2:0] {
    ready_state,
    dte_waiting_state,
    dce_waiting_state,
    data_transfer_state,
    call_collision_state,
    dte_clear_request_state,
    dce_clear_indication_state
  } pcc_call_t;

  // data transfer substates
  typedef enum logic [1:0] {
    flow_ready_substate,
    dte_reset_request_substate,
    dce_reset_indication_substate
  } pcc_sub_t;

  // interface-wide restart state
  typedef enum logic [1:0] {
    RS_IDLE,
    RS_DTE_REQ,
    RS_DCE_IND
  } pcc_rs_t;

  // =====================================================
  // packets received from the terminal
  typedef enum logic [3:0] {
    PK_CALL_REQ, PK_CALL_ACC, PK_CLR_REQ, PK_CLR_CONF, PK_DATA, PK_INTR,
    PK_FLOW, PK_RST_REQ, PK_RST_CONF, PK_RSTART_REQ, PK_RSTART_CONF
  } pcc_pkt_t;

  // events from the network side
  typedef enum logic [2:0] {
    NE_INCOMING_CALL, NE_CALL_CONNECTED, NE_CLR_CONF, NE_CLR_IND,
    NE_RST_CONF, NE_RST_IND, NE_RSTART_CONF, NE_RSTART_IND
  } pcc_net_t;

  // indication kinds and causes
  typedef enum logic [1:0] {IND_CLEAR, IND_RESET, IND_RESTART} pcc_ind_t;
  typedef enum logic [1:0] {CAUSE_NONE, CAUSE_LOCAL_PROC, CAUSE_REMOTE_PROC} pcc_cause_t;

endpackage

// >>> src/pcc_tick_gen.sv
/*
  prescaler that turns core_clk into the slow time-out tick.
  assumes synchronous active-high reset.
*/
`timescale 1ns/1ps
module pcc_tick_gen
  import pcc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  pcc_tick_if.src t
);

  // =====================================================
  // prescaler
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  logic [TICK_W-1:0] cnt_r; // cycles since last tick
  logic [TICK_W-1:0] cnt_nxt;
  logic tick_r; // registered tick pulse
  logic tick_nxt;

  // next count; wraps so the tick period is exact
  always_comb begin
    if (cnt_r == TICK_LAST) begin
      cnt_nxt = '0;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + TICK_W'(1);
      tick_nxt = 1'b0;
    end
  end

  // registers only
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign t.tick = tick_r;

endmodule

// >>> src/pcc_tick_if.sv
/*
  carries the time-out tick from the prescaler to the checker.
  assumes both ends sit on core_clk.
*/
`timescale 1ns/1ps
interface pcc_tick_if;
  logic tick; // one-cycle pulse every tick period
  modport src (output tick);
  modport snk (input tick);
endinterface
